// [include/tap_pkg.sv]
package tap_pkg;

  // ------------------------------------------------
  // timing
  // ------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  // event output held long enough for a slow tool
  localparam int EVT_HOLD_NS = 80;
  localparam int EVT_HOLD_I =
    (EVT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] EVT_HOLD_CYCLES = 4'(EVT_HOLD_I);
  // sync depth plus one before strap capture
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // ------------------------------------------------
  // message port
  // ------------------------------------------------
  localparam int MSG_WIDTH = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [15:0] REDUCED_MASK = 16'h0fff;
  localparam logic [1:0] SEO_IDLE = 2'h3;
  localparam logic [1:0] SEO_START = 2'h0;
  localparam logic [1:0] SEO_BODY = 2'h3;
  localparam logic [1:0] SEO_END = 2'h1;
  localparam logic [1:0] SEO_SOLO = 2'h2;

  typedef struct packed {
    logic        last;
    logic [15:0] data;
  } tap_word_t;

  typedef enum logic {
    LK_IDLE,
    LK_PACKET
  } tap_link_state_t;

endpackage

// [rtl/tap_sync.sv]
module tap_sync
  import tap_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // level in and out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } tap_sync_t;

  tap_sync_t s_reg;
  tap_sync_t s_next;

  // first stage feeds only the second
  always_comb
  begin
    s_next.meta = d;
    s_next.held = s_reg.meta;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign q = s_reg.held;

endmodule

// [rtl/tap_fifo.sv]
module tap_fifo
  import tap_pkg::*;
#(
  parameter int WIDTH = 17,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // write side
  input  wire logic             wClk,
  input  wire logic             wRstN,
  input  wire logic             wValid,
  output logic                  wReady,
  input  wire logic [WIDTH-1:0] wData,
  // read side
  input  wire logic             rClk,
  input  wire logic             rRstN,
  output logic                  rValid,
  input  wire logic             rReady,
  output logic      [WIDTH-1:0] rData
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 bin;
    logic [AW:0]                 gray;
  } tap_fw_t;

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
  } tap_fr_t;

  tap_fw_t     w_reg;
  tap_fw_t     w_next;
  tap_fr_t     r_reg;
  tap_fr_t     r_next;
  logic [AW:0] rGraySync;
  logic [AW:0] wGraySync;
  logic [AW:0] wBinInc;
  logic [AW:0] rBinInc;

  // gray pointers cross, never binary ones
  tap_sync #(.WIDTH(AW + 1)) uSyncR (
    .clk  (wClk),
    .rstN (wRstN),
    .d    (r_reg.gray),
    .q    (rGraySync)
  );

  tap_sync #(.WIDTH(AW + 1)) uSyncW (
    .clk  (rClk),
    .rstN (rRstN),
    .d    (w_reg.gray),
    .q    (wGraySync)
  );

  // full when top two gray bits differ and the rest match
  assign wReady = w_reg.gray != {~rGraySync[AW:AW-1], rGraySync[AW-2:0]};
  assign rValid = r_reg.gray != wGraySync;
  assign rData = w_reg.mem[r_reg.bin[AW-1:0]];
  assign wBinInc = w_reg.bin + 1'b1;
  assign rBinInc = r_reg.bin + 1'b1;

  // write side
  always_comb
  begin
    w_next = w_reg;
    if (wValid && wReady)
    begin
      w_next.mem[w_reg.bin[AW-1:0]] = wData;
      w_next.bin = wBinInc;
      w_next.gray = wBinInc ^ (wBinInc >> 1);
    end
  end

  // read side
  always_comb
  begin
    r_next = r_reg;
    if (rValid && rReady)
    begin
      r_next.bin = rBinInc;
      r_next.gray = rBinInc ^ (rBinInc >> 1);
    end
  end

  always_ff @(posedge wClk or negedge wRstN)
  begin
    if (!wRstN)
      w_reg <= '0;
    else
      w_reg <= w_next;
  end

  always_ff @(posedge rClk or negedge rRstN)
  begin
    if (!rRstN)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  a_fifo_no_overrun: assert property (@(posedge wClk) disable iff (!wRstN)
    !wReady |=> w_reg.bin == $past(w_reg.bin))
    else $error("write pointer moved while full");

endmodule

// [rtl/tap_trace_aux_port.sv]
// Operation
// (R1) message data is 12 bits wide reduced, 16 bits full port
// (R2) start/end outputs mark first and last cycle of each packet
// (R3) message clock output times data and start/end lines
// (R4) each watchpoint or breakpoint hit pulses the event output; here only watchHit loads the pulse, breakpoint hits have no input
// (R5) event input after reset starts trace sync or a breakpoint
// (R6) event input held in reset forces debug mode, no code runs
// (R7) shared line raises interrupt three or starts DMA channel three
// (R8) shared line request may invoke DMA gather-data function
// (R9) shared line sampled at reset as boot configuration input
// (R10) tool drives watchdog-disable high to stop external watchdog
// (R11) tools may use watchdog-disable to signal presence downstream
// (R12) tools arbitrate by request and grant, not wired to device
// (R13) outputs change on message clock rise, stable at its fall
module tap_trace_aux_port
  import tap_pkg::*;
(
  // system side
  input  wire logic        clk,
  input  wire logic        nrst,
  // link clock
  input  wire logic        traceClk,
  // trace message stream
  input  wire tap_word_t   msgIn,
  input  wire logic        msgValid,
  output logic             msgReady,
  // configuration
  input  wire logic        fullPort,
  input  wire logic        evtiBreakSel,
  input  wire logic        irqToDma,
  input  wire logic        dmaGather,
  // core side events
  input  wire logic        watchHit,
  input  wire logic        debugExit,
  output logic             debugModeEntry,
  output logic             coreRunEnable,
  output logic             bootConfigInput,
  output logic             traceSyncReq,
  output logic             breakpointReq,
  output logic             interruptRequestThree,
  output logic             dmaChan3Req,
  output logic             dmaGatherReq,
  // pins
  input  wire logic        eventInN,
  input  wire logic        bootIrqSharedLine,
  output logic             eventOutN,
  output logic             msgClkOut,
  output logic [15:0]      msgDataOut,
  output logic [1:0]       msgSeoN
);

  // ------------------------------------------------
  // reset release, one copy per domain
  // ------------------------------------------------
  logic [1:0] rstSys_reg;
  logic [1:0] rstLink_reg;
  logic       rstSysN;
  logic       rstLinkN;

  // asserted at once, released after two edges
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rstSys_reg <= 2'h0;
    else
      rstSys_reg <= {rstSys_reg[0], 1'b1};
  end

  always_ff @(posedge traceClk or negedge nrst)
  begin
    if (!nrst)
      rstLink_reg <= 2'h0;
    else
      rstLink_reg <= {rstLink_reg[0], 1'b1};
  end

  assign rstSysN = rstSys_reg[1];
  assign rstLinkN = rstLink_reg[1];

  // ------------------------------------------------
  // pin inputs
  // ------------------------------------------------
  logic [1:0] pinSync;
  logic       evtiLevel;
  logic       shareLevel;

  // event input is active low
  tap_sync #(.WIDTH(2)) uPinSync (
    .clk  (clk),
    .rstN (rstSysN),
    .d    ({~eventInN, bootIrqSharedLine}),
    .q    (pinSync)
  );

  assign evtiLevel = pinSync[1];
  assign shareLevel = pinSync[0];

  // ------------------------------------------------
  // message buffer toward the link
  // ------------------------------------------------
  tap_word_t fifoIn;
  tap_word_t fifoOut;
  logic      fifoValid;
  logic      fifoTake;

  // (R1) reduced port clears upper lanes
  always_comb
  begin
    fifoIn = msgIn;
    if (!fullPort)
      fifoIn.data = msgIn.data & REDUCED_MASK;
  end

  tap_fifo #(.WIDTH($bits(tap_word_t)), .DEPTH(FIFO_DEPTH)) uFifo (
    .wClk   (clk),
    .wRstN  (rstSysN),
    .wValid (msgValid),
    .wReady (msgReady),
    .wData  (fifoIn),
    .rClk   (traceClk),
    .rRstN  (rstLinkN),
    .rValid (fifoValid),
    .rReady (fifoTake),
    .rData  (fifoOut)
  );

  // ------------------------------------------------
  // link side: message clock and packet framing
  // ------------------------------------------------
  typedef struct packed {
    logic            mck;
    logic [15:0]     data;
    logic [1:0]      seoN;
    tap_link_state_t state;
  } tap_link_t;

  tap_link_t lk_reg;
  tap_link_t lk_next;

  // (R13) words are taken only where the clock rises
  assign fifoTake = !lk_reg.mck;

  // (R3) message clock is half the link clock
  always_comb
  begin
    lk_next = lk_reg;
    lk_next.mck = !lk_reg.mck;
    if (!lk_reg.mck)
    begin
      lk_next.data = 16'h0000;
      lk_next.seoN = SEO_IDLE;
      if (fifoValid)
      begin
        lk_next.data = fifoOut.data;
        // (R2) mark first and last word
        if (lk_reg.state == LK_IDLE)
          lk_next.seoN = fifoOut.last ? SEO_SOLO : SEO_START;
        else
          lk_next.seoN = fifoOut.last ? SEO_END : SEO_BODY;
        lk_next.state = fifoOut.last ? LK_IDLE : LK_PACKET;
      end
      else if (lk_reg.state == LK_PACKET)
        lk_next.seoN = SEO_BODY;  // underrun keeps the packet open
    end
  end

  always_ff @(posedge traceClk or negedge rstLinkN)
  begin
    if (!rstLinkN)
    begin
      lk_reg.mck <= 1'b0;
      lk_reg.data <= 16'h0000;
      lk_reg.seoN <= SEO_IDLE;
      lk_reg.state <= LK_IDLE;
    end
    else
      lk_reg <= lk_next;
  end

  assign msgClkOut = lk_reg.mck;
  assign msgDataOut = lk_reg.data;
  assign msgSeoN = lk_reg.seoN;

  // ------------------------------------------------
  // system side: straps, event input, shared line
  // ------------------------------------------------
  typedef struct packed {
    logic [1:0] strapCnt;
    logic       started;
    logic       debugEntry;
    logic       coreRun;
    logic       bootCfg;
    logic       evtiPrev;
    logic       sharePrev;
    logic       syncReq;
    logic       brkReq;
    logic       interrupt_request_three;
    logic       dma3;
    logic       gather;
    logic [3:0] evtoCnt;
    logic       evtoN;
  } tap_sys_t;

  tap_sys_t sy_reg;
  tap_sys_t sy_next;
  logic     evtiEdge;
  logic     shareRise;

  assign evtiEdge = sy_reg.started && evtiLevel && !sy_reg.evtiPrev;
  assign shareRise = sy_reg.started && shareLevel && !sy_reg.sharePrev;

  // sync, break, DMA and gather requests are one-cycle pulses; interrupt three is a level
  always_comb
  begin
    sy_next = sy_reg;
    sy_next.syncReq = 1'b0;
    sy_next.brkReq = 1'b0;
    sy_next.dma3 = 1'b0;
    sy_next.gather = 1'b0;
    sy_next.evtiPrev = evtiLevel;
    sy_next.sharePrev = shareLevel;
    if (!sy_reg.started)
    begin
      // wait until synchronisers hold the reset-time level
      if (sy_reg.strapCnt != 2'h0)
        sy_next.strapCnt = sy_reg.strapCnt - 2'h1;
      else
      begin
        sy_next.started = 1'b1;
        // (R6) event input held through reset halts the core
        sy_next.debugEntry = evtiLevel;
        sy_next.coreRun = !evtiLevel;
        // (R9) boot configuration strap
        sy_next.bootCfg = shareLevel;
      end
    end
    else
    begin
      if (sy_reg.debugEntry && debugExit)
      begin
        sy_next.debugEntry = 1'b0;
        sy_next.coreRun = 1'b1;
      end
      // (R5) event input after reset
      if (evtiEdge)
      begin
        if (evtiBreakSel)
          sy_next.brkReq = 1'b1;
        else
          sy_next.syncReq = 1'b1;
      end
      // (R7) route to interrupt or DMA channel three
      if (irqToDma)
      begin
        sy_next.interrupt_request_three = 1'b0;
        if (shareRise)
        begin
          // (R8) gather-data instead of a plain transfer
          if (dmaGather)
            sy_next.gather = 1'b1;
          else
            sy_next.dma3 = 1'b1;
        end
      end
      else
        sy_next.interrupt_request_three = shareLevel;
    end
    // (R4) retriggerable event output pulse
    if (watchHit)
      sy_next.evtoCnt = EVT_HOLD_CYCLES;
    else if (sy_reg.evtoCnt != 4'h0)
      sy_next.evtoCnt = sy_reg.evtoCnt - 4'h1;
    sy_next.evtoN = sy_next.evtoCnt == 4'h0;
  end

  always_ff @(posedge clk or negedge rstSysN)
  begin
    if (!rstSysN)
    begin
      sy_reg <= '0;
      sy_reg.strapCnt <= STRAP_WAIT;
      sy_reg.evtoN <= 1'b1;
    end
    else
      sy_reg <= sy_next;
  end

  // core side outputs and the event output pin
  assign debugModeEntry = sy_reg.debugEntry;
  assign coreRunEnable = sy_reg.coreRun;
  assign bootConfigInput = sy_reg.bootCfg;
  assign traceSyncReq = sy_reg.syncReq;
  assign breakpointReq = sy_reg.brkReq;
  assign interruptRequestThree = sy_reg.interrupt_request_three;
  assign dmaChan3Req = sy_reg.dma3;
  assign dmaGatherReq = sy_reg.gather;
  assign eventOutN = sy_reg.evtoN;

  // ------------------------------------------------
  // checks
  // ------------------------------------------------
  // (R1) reduced port masking
  a_reduced_upper_zero: assert property (@(posedge clk) disable iff (!rstSysN) // (R1)
    (msgValid && !fullPort) |-> fifoIn.data[15:12] == 4'h0)
    else $error("upper message lanes not cleared");

  // (R2) packet opens with start code
  a_seo_start_open: assert property (@(posedge traceClk) disable iff (!rstLinkN) // (R2)
    (lk_reg.state == LK_PACKET && $past(lk_reg.state) == LK_IDLE) |-> msgSeoN == SEO_START)
    else $error("packet opened without start code");

  // (R2) packet closes with end code
  a_seo_end_close: assert property (@(posedge traceClk) disable iff (!rstLinkN) // (R2)
    (lk_reg.state == LK_IDLE && $past(lk_reg.state) == LK_PACKET) |-> msgSeoN == SEO_END)
    else $error("packet closed without end code");

  // (R3) message clock toggles on each rising link edge
  a_msgclk_runs: assert property (@(posedge traceClk) disable iff (!rstLinkN) // (R3)
    msgClkOut |=> !msgClkOut ##1 msgClkOut)
    else $error("message clock stalled");

  // (R13) outputs hold over the sampling edge
  a_stable_at_sample: assert property (@(posedge traceClk) disable iff (!rstLinkN) // (R13)
    !msgClkOut |-> $stable(msgDataOut) && $stable(msgSeoN))
    else $error("message outputs moved at sampling edge");

  // (R4) event output width
  a_event_out_width: assert property (@(posedge clk) disable iff (!rstSysN) // (R4)
    watchHit |=> !eventOutN [*8])
    else $error("event output pulse too short");

  // (R5) event input edge to request
  a_evti_request: assert property (@(posedge clk) disable iff (!rstSysN) // (R5)
    evtiEdge |=> (evtiBreakSel ? breakpointReq : traceSyncReq) ##1 !traceSyncReq && !breakpointReq)
    else $error("event input not answered by one pulse");

  // (R6) debug entry keeps code stopped
  a_debug_holds_core: assert property (@(posedge clk) disable iff (!rstSysN) // (R6)
    debugModeEntry |-> !coreRunEnable)
    else $error("core runs in forced debug mode");

  // (R7) interrupt follows line when not routed to DMA
  a_irq_follows: assert property (@(posedge clk) disable iff (!rstSysN) // (R7)
    (sy_reg.started && !irqToDma) |=> interruptRequestThree == $past(shareLevel))
    else $error("interrupt three does not follow line");

  // (R8) gather request on routed edge
  a_gather_request: assert property (@(posedge clk) disable iff (!rstSysN) // (R8)
    (shareRise && irqToDma && dmaGather) |=> dmaGatherReq && !dmaChan3Req)
    else $error("gather request missing");

  // (R9) boot strap stays fixed once taken
  a_boot_strap_hold: assert property (@(posedge clk) disable iff (!rstSysN) // (R9)
    (sy_reg.started && $past(sy_reg.started)) |-> $stable(bootConfigInput))
    else $error("boot configuration changed after reset");

  c_solo_packet: cover property (@(posedge traceClk) disable iff (!rstLinkN)
    msgSeoN == SEO_SOLO);
  c_long_packet: cover property (@(posedge traceClk) disable iff (!rstLinkN)
    msgSeoN == SEO_START ##2 msgSeoN == SEO_BODY);
  c_forced_debug: cover property (@(posedge clk) disable iff (!rstSysN)
    debugModeEntry ##1 debugExit);
  c_dma_gather: cover property (@(posedge clk) disable iff (!rstSysN)
    dmaGatherReq);

endmodule

// [bench/tap_tool_model.sv]
module tap_tool_model
  import tap_pkg::*;
(
  // message pins from the device
  input  wire logic        msgClkOut,
  input  wire logic [15:0] msgDataOut,
  input  wire logic [1:0]  msgSeoN,
  // tool-only lines, not wired to the device
  output logic             wdogDisable,
  output logic             arbRequest,
  // captured words for the bench
  output logic [17:0]      gotWord,
  output int               gotCount,
  output int               stabErr
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        inPkt;
  logic [17:0] snap;

  // watchdog-disable low: nothing outside to stop
  assign wdogDisable = 1'b0;
  assign arbRequest = 1'b0;

  initial
  begin
    inPkt = 1'b0;
    gotCount = 0;
    stabErr = 0;
    gotWord = '0;
    snap = {SEO_IDLE, 16'h0000};
  end

  // snapshot just after launch, compared at the sampling edge
  // wait first: clock and data ports settle in one step in any order
  always @(posedge msgClkOut)
  begin
    #1;
    snap = {msgSeoN, msgDataOut};
  end

  // sample at the fall; idle and body share a code, so track framing
  always @(negedge msgClkOut)
  begin
    if ($time > 100)
    begin
      if ({msgSeoN, msgDataOut} !== snap)
        stabErr++;
      if (msgSeoN == SEO_START || msgSeoN == SEO_SOLO || msgSeoN == SEO_END || inPkt)
      begin
        gotWord = {msgSeoN, msgDataOut};
        gotCount++;
      end
      inPkt = (msgSeoN == SEO_START) || (inPkt && msgSeoN != SEO_END);
    end
  end
endmodule

// [bench/tap_trace_aux_port_test.sv]
module tap_trace_aux_port_test
  import tap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, nrst, traceClk, msgValid, msgReady, fullPort, evtiBreakSel;
  logic irqToDma, dmaGather, watchHit, debugExit, debugModeEntry, coreRunEnable;
  logic bootConfigInput, traceSyncReq, breakpointReq, interruptRequestThree;
  logic dmaChan3Req, dmaGatherReq, eventInN, bootIrqSharedLine, eventOutN, msgClkOut;
  logic [15:0] msgDataOut;
  logic [1:0]  msgSeoN;
  logic [17:0] gotWord;
  logic [17:0] expQ[$];
  tap_word_t   msgIn;
  int          gotCount, stabErr, fails, total_checks, cyc, sawFull;
  int          pc[5];

  tap_trace_aux_port DUT (
    .clk, .nrst, .traceClk, .msgIn, .msgValid, .msgReady, .fullPort, .evtiBreakSel,
    .irqToDma, .dmaGather, .watchHit, .debugExit, .debugModeEntry, .coreRunEnable,
    .bootConfigInput, .traceSyncReq, .breakpointReq, .interruptRequestThree,
    .dmaChan3Req, .dmaGatherReq, .eventInN, .bootIrqSharedLine, .eventOutN,
    .msgClkOut, .msgDataOut, .msgSeoN);

  tap_tool_model tool (
    .msgClkOut, .msgDataOut, .msgSeoN, .wdogDisable(), .arbRequest(),
    .gotWord, .gotCount, .stabErr);

  // ------------------------------------------------
  // clocks and watchdog
  // ------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // link clock offset by 3 ns; every fifth of its edges still lines up with a clk edge
  initial
  begin
    traceClk = 1'b0;
    #3;
    forever #32 traceClk = ~traceClk;
  end

  // cuts a hang short; the tests need about one to two thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      $display("[FAIL] %0t timeout", $time);
      results();
    end
  end

  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // counts pulses and low cycles over n clock edges
  task automatic watch(input int n);
    pc = '{default: 0};
    repeat (n)
    begin
      @(posedge clk);
      pc[0] += int'(traceSyncReq === 1'b1);
      pc[1] += int'(breakpointReq === 1'b1);
      pc[2] += int'(dmaChan3Req === 1'b1);
      pc[3] += int'(dmaGatherReq === 1'b1);
      pc[4] += int'(eventOutN === 1'b0);
    end
  endtask

  // offers one packet and notes each word as it is taken
  task automatic sendPkt(input int len, input logic fp);
    tap_word_t w;
    logic [1:0] seo;
    for (int i = 0; i < len; i++)
    begin
      w.last = (i == len - 1);
      w.data = 16'($urandom);
      msgIn <= w;
      msgValid <= 1'b1;
      fullPort <= fp;
      do
      begin
        @(posedge clk);
        sawFull += int'(msgReady !== 1'b1);
      end
      while (msgReady !== 1'b1);
      seo = (len == 1) ? SEO_SOLO : (i == 0) ? SEO_START : w.last ? SEO_END : SEO_BODY;
      expQ.push_back({seo, fp ? w.data : (w.data & REDUCED_MASK)});
    end
  endtask

  task automatic results();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // compares every word the tool captured with the oldest note
  always @(gotCount)
  begin
    // the word port may update after the count port in the same step
    #1;
    if (expQ.size() == 0)
      chk(gotWord, 18'h3ffff, "word with none expected");
    else
      chk(gotWord, expQ.pop_front(), "message word");
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial
  begin
    {nrst, msgValid, fullPort, evtiBreakSel, irqToDma, dmaGather, watchHit, debugExit} = '0;
    msgIn = '0;
    eventInN = 1'b0;
    bootIrqSharedLine = 1'b1;
    void'($urandom(32'hd8f0));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    // pins held past strap capture
    repeat (10) @(posedge clk);
    chk(debugModeEntry, 1'b1, "debug entry");
    chk(coreRunEnable, 1'b0, "core held");
    chk(bootConfigInput, 1'b1, "boot strap");
    eventInN <= 1'b1;
    bootIrqSharedLine <= 1'b0;
    debugExit <= 1'b1;
    @(posedge clk);
    debugExit <= 1'b0;
    watch(6);
    chk(coreRunEnable, 1'b1, "core released");
    $display("strap test done");

    // held event input gives one pulse of the selected kind
    for (int s = 0; s < 2; s++)
    begin
      evtiBreakSel <= s[0];
      eventInN <= 1'b0;
      watch(12);
      chk(18'(pc[0]), 18'(1 - s), "trace sync pulses");
      chk(18'(pc[1]), 18'(s), "breakpoint pulses");
      eventInN <= 1'b1;
      watch(6);
    end
    $display("event input test done");

    // shared line: interrupt, dma channel, gather
    for (int m = 0; m < 3; m++)
    begin
      irqToDma <= (m > 0);
      dmaGather <= (m == 2);
      bootIrqSharedLine <= 1'b1;
      watch(8);
      chk(18'(pc[2]), 18'(m == 1), "dma ch3 pulses");
      chk(18'(pc[3]), 18'(m == 2), "gather pulses");
      chk(interruptRequestThree, m == 0, "irq high");
      bootIrqSharedLine <= 1'b0;
      watch(8);
      chk(interruptRequestThree, 1'b0, "irq low");
    end
    $display("shared line test done");

    // single hit, then a retrigger three cycles in
    for (int g = 0; g < 4; g += 3)
    begin
      watchHit <= 1'b1;
      @(posedge clk);
      watchHit <= 1'b0;
      if (g > 0)
      begin
        repeat (g - 1) @(posedge clk);
        watchHit <= 1'b1;
        @(posedge clk);
        watchHit <= 1'b0;
      end
      watch(14);
      chk(18'(pc[4]), 18'(EVT_HOLD_CYCLES), "event out low cycles");
    end
    $display("event output test done");

    // back-to-back packets, some longer than the buffer
    sendPkt(1, 1'b1);
    for (int p = 0; p < 12; p++)
      sendPkt(1 + int'($urandom % 12), 1'($urandom));
    msgValid <= 1'b0;
    for (int k = 0; k < 4000 && expQ.size() > 0; k++)
      @(posedge clk);
    chk(18'(expQ.size()), 18'h0, "words left");
    chk(18'(sawFull > 0), 18'h1, "buffer refused");
    chk(18'(stabErr), 18'h0, "unstable at sample");
    $display("message stream test done");
    results();
  end
endmodule
